// file: hdl/cpu_bus_cfg.svh
// constants for the processor bus sequencer
// assumes inclusion by bare name from hdl/ sources
`ifndef CPU_BUS_CFG_SVH
`define CPU_BUS_CFG_SVH
`define ADDR_W 16
`define DATA_W 8
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3
`define RESET_PC 16'h0000
`define RESET_MIN_CYCLES 3
`define IO_PORT_W 8
// status word bit positions
`define ST_INTA 0
`define ST_WO_N 1
`define ST_STACK 2
`define ST_HLTA 3
`define ST_OUT 4
`define ST_M1 5
`define ST_INP 6
`define ST_MEMR 7
`define ST_NONE 8'h00
`endif

// file: hdl/cpu_bus_pkg.sv
// types shared by the bus sequencer and its helpers
// assumes a synthesis flow that compiles packages first
package cpu_bus_pkg;
	// machine cycle kinds
	typedef enum logic [2:0] {
		cyc_fetch = 3'b000,
		cyc_mem_read = 3'b001,
		cyc_mem_write = 3'b010,
		cyc_io_in = 3'b011,
		cyc_io_out = 3'b100,
		cyc_irq_ack = 3'b101,
		cyc_halt_ack = 3'b110
	} cycle_type;
	// bus sequencer states
	typedef enum logic [2:0] {
		st_first = 3'b000,
		st_two = 3'b001,
		st_stall = 3'b010,
		st_third = 3'b011,
		st_released = 3'b100,
		st_halted = 3'b101,
		st_idle = 3'b110
	} bus_state_type;
endpackage : cpu_bus_pkg

// file: hdl/cpu_bus_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_fifo #(
	parameter int width = 8,
	parameter int depth = 8,
	parameter int ptr_w = 3
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	logic [width-1:0] mem [depth]; // storage words
	logic [ptr_w-1:0] wr_ptr; // write index
	logic [ptr_w-1:0] rd_ptr; // read index
	logic [ptr_w:0] count; // occupancy
	logic push; // accepted write
	logic pop; // accepted read

	assign in_ready = (count != ptr_w'(0) + (ptr_w+1)'(depth)) ;
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// storage written without reset, contents only read when valid
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and occupancy
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (ptr_w+1)'(push) - (ptr_w+1)'(pop);
		end
	end
endmodule : cpu_bus_fifo
`default_nettype wire

// file: hdl/cpu_bus_irq.sv
// interrupt enable flip-flop and request recognition
// assumes the sequencer flags instruction ends and fetch cycle starts
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_irq (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic enable_irq_instruction,
	input wire logic disable_irq_instruction,
	input wire logic irq_line,
	input wire logic instr_end,
	input wire logic halted,
	input wire logic released,
	input wire logic fetch_start,
	output logic irq_enable_state,
	output logic irq_taken
);
	logic pending; // accepted request awaiting its fetch cycle

	// request seen only when enabled and bus not released
	assign irq_taken = irq_line && irq_enable_state && !released
		&& (instr_end || halted);

	// enable flip-flop; reset clears it
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			irq_enable_state <= 1'b0;
		else if (pending && fetch_start)
			irq_enable_state <= 1'b0;
		else if (disable_irq_instruction)
			irq_enable_state <= 1'b0;
		else if (enable_irq_instruction)
			irq_enable_state <= 1'b1;
	end

	// remember acceptance until the acknowledge fetch begins
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			pending <= 1'b0;
		else if (irq_taken)
			pending <= 1'b1;
		else if (fetch_start)
			pending <= 1'b0;
	end
endmodule : cpu_bus_irq
`default_nettype wire

// file: hdl/cpu_bus_control.sv
// bus and control sequencer of an 8-bit processor, pin side
// assumes cycle requests arrive through the fifo from the core
//
// Summary of operation
// - drive 16-bit three-state address bus
// - status word on data bus first_state
// - cycle start strobe each machine cycle
// - bus_input_phase high while data bus inputs
// - stall while ready low after address
// - stall indicator high during stall states
// - active-low store strobe, data held stable
// - release buses during third_state of reads, after writes end
// - release request seen halted or ready
// - released state floats buses, acknowledge high
// - acknowledge at third_state reads, later writes
// - acknowledge first, buses float next phase
// - enable flip-flop set, cleared by instructions
// - enable cleared at accepted interrupt fetch
// - irq sampled at instruction end or halted
// - irq ignored when released or disabled
// - reset clears pc, enable and acknowledge
// - reset leaves programmer registers untouched
`timescale 1ns/1ns
`default_nettype none
`include "cpu_bus_cfg.svh"
module cpu_bus_control (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic phase_one_clock,
	input wire logic phase_two_clock,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [2:0] req_kind,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic req_last,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	input wire logic enable_irq_instruction,
	input wire logic disable_irq_instruction,
	input wire logic halt_request,
	output logic [15:0] addr_out,
	output logic addr_oe_b,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_b,
	output logic cycle_start_strobe,
	output logic bus_input_phase,
	output logic stall_indicator,
	output logic store_strobe_n,
	input wire logic ready,
	input wire logic bus_release_request,
	output logic bus_release_ack,
	input wire logic irq_line,
	output logic irq_enable_state,
	output logic irq_taken,
	output logic [15:0] program_counter
);
	import cpu_bus_pkg::*;

	// 3 kind + 1 last + 16 addr + 8 data
	localparam int fifo_w = 3 + 1 + `ADDR_W + `DATA_W;

	// sequencer and cycle context
	bus_state_type state; // sequencer state
	bus_state_type next_state; // combinational successor
	cycle_type kind; // current cycle kind
	logic last; // current cycle ends an instruction
	logic [7:0] wdata; // held write data
	logic hold_seen; // release request latched at ready point
	logic [1:0] release_delay; // acknowledge to float spacing
	// phase edge detection
	logic p1_prev; // phase one edge detect
	logic p2_prev; // phase two edge detect
	logic p1_rise; // phase one rising
	logic p2_rise; // phase two rising
	// request queue head
	logic q_valid; // fifo head present
	logic q_ready; // fifo head taken
	logic [fifo_w-1:0] q_data; // fifo head word
	logic [fifo_w-1:0] in_word; // packed request
	logic instr_end; // instruction completes this cycle
	logic fetch_start; // fetch cycle starts now
	logic is_write; // cycle drives data

	// status word for a cycle kind
	function automatic logic [7:0] status_of(input cycle_type k);
		logic [7:0] s;
		// bits start clear; write-out bit is active low
		s = `ST_NONE;
		s[`ST_WO_N] = 1'b1;
		unique case (k)
			cyc_fetch: begin s[`ST_M1] = 1'b1; s[`ST_MEMR] = 1'b1; end
			cyc_mem_read: s[`ST_MEMR] = 1'b1;
			cyc_mem_write: s[`ST_WO_N] = 1'b0;
			cyc_io_in: s[`ST_INP] = 1'b1;
			cyc_io_out: begin s[`ST_OUT] = 1'b1; s[`ST_WO_N] = 1'b0; end
			cyc_irq_ack: begin s[`ST_INTA] = 1'b1; s[`ST_M1] = 1'b1; end
			cyc_halt_ack: begin s[`ST_HLTA] = 1'b1; s[`ST_MEMR] = 1'b1; end
			// code 3'b111 names no cycle, so no status
			default: s = `ST_NONE;
		endcase
		return s;
	endfunction : status_of

	// true for cycles that drive data out
	function automatic logic writes(input cycle_type k);
		return (k == cyc_mem_write) || (k == cyc_io_out);
	endfunction : writes

	assign in_word = {req_kind, req_last, req_addr, req_wdata};
	assign p1_rise = phase_one_clock && !p1_prev;
	assign p2_rise = phase_two_clock && !p2_prev;
	assign is_write = writes(kind);

	// request queue; a full queue stalls the core via req_ready
	cpu_bus_fifo #(.width(fifo_w), .depth(`FIFO_DEPTH), .ptr_w(`FIFO_PTR_W)) u_fifo (
		.clock(clock),
		.rst_b(rst_b),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(in_word),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	// head consumed when a new cycle begins
	// a latched release blocks the next cycle start
	assign q_ready = (state == st_idle) && p1_rise && !hold_seen;
	assign fetch_start = q_ready && q_valid
		&& (cycle_type'(q_data[fifo_w-1 -: 3]) == cyc_fetch
		|| cycle_type'(q_data[fifo_w-1 -: 3]) == cyc_irq_ack);
	assign instr_end = (state == st_third) && p1_rise && last;

	// interrupt enable and acceptance
	// halted and released decoded here for the irq block
	cpu_bus_irq u_irq (
		.clock(clock),
		.rst_b(rst_b),
		.enable_irq_instruction(enable_irq_instruction),
		.disable_irq_instruction(disable_irq_instruction),
		.irq_line(irq_line),
		.instr_end(instr_end),
		.halted(state == st_halted),
		.released(state == st_released),
		.fetch_start(fetch_start),
		.irq_enable_state(irq_enable_state),
		.irq_taken(irq_taken)
	);

	// phase edge history, phases sampled as synchronous inputs
	// previous levels feed the rising-edge detectors
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			p1_prev <= 1'b0;
			p2_prev <= 1'b0;
		end
		else
		begin
			p1_prev <= phase_one_clock;
			p2_prev <= phase_two_clock;
		end
	end

	// next state; each step advances on a phase one rising edge, except the interrupt wake from halted
	always_comb
	begin
		next_state = state;
		unique case (state)
			// idle: start a queued cycle, or hand the buses over
			st_idle:
				if (p1_rise && !hold_seen && q_valid)
					next_state = st_first;
				else if (p1_rise && hold_seen)
					next_state = st_released;
			// first_state: status word on the bus for one step
			st_first:
				if (p1_rise)
					next_state = st_two;
			// ready sampled once per step; low keeps us stalled
			st_two, st_stall:
				if (p1_rise)
					next_state = ready ? st_third : st_stall;
			// third_state: data moved; a halt cycle parks afterwards
			st_third:
				if (p1_rise)
					next_state = (kind == cyc_halt_ack) ? st_halted : st_idle;
			// halted: only a release or an interrupt wakes it
			st_halted:
				if (p1_rise && bus_release_request)
					next_state = st_released;
				else if (irq_taken)
					next_state = st_idle;
			// released: wait for the request to drop
			st_released:
				if (p1_rise && !bus_release_request)
					next_state = st_idle;
			// unused code recovers to idle
			default: next_state = st_idle;
		endcase
	end

	// state register
	// reset parks the sequencer idle, fetch starts at zero
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			state <= st_idle;
		else
			state <= next_state;
	end

	// latch release request at the ready point only; halted goes straight to released
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			hold_seen <= 1'b0;
		// ready point: take the request as it stands
		else if ((state == st_two || state == st_stall) && p1_rise && ready)
			hold_seen <= bus_release_request;
		// request consumed once the buses are released
		else if (state == st_released)
			hold_seen <= 1'b0;
	end

	// cycle context taken from the fifo head
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			kind <= cyc_fetch;
			last <= 1'b0;
			wdata <= `ST_NONE;
			addr_out <= `RESET_PC;
			// pc cleared along with the cycle context; working registers sit in the core
			program_counter <= `RESET_PC;
		end
		else if (q_ready && q_valid)
		begin
			// new cycle: latch kind, address and write data
			kind <= cycle_type'(q_data[fifo_w-1 -: 3]);
			last <= q_data[`ADDR_W + `DATA_W];
			addr_out <= q_data[`DATA_W +: `ADDR_W];
			wdata <= q_data[`DATA_W-1:0];
			// a fetch moves the pc past the opcode
			if (cycle_type'(q_data[fifo_w-1 -: 3]) == cyc_fetch)
				program_counter <= q_data[`DATA_W +: `ADDR_W] + 16'h0001;
		end
	end

	// pin strobes and data path; programmer registers live elsewhere
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// reset: strobes idle, data bus floated
			cycle_start_strobe <= 1'b0;
			bus_input_phase <= 1'b0;
			stall_indicator <= 1'b0;
			store_strobe_n <= 1'b1;
			data_out <= `ST_NONE;
			data_oe_b <= 1'b1;
			rsp_data <= `ST_NONE;
			rsp_valid <= 1'b0;
		end
		else
		begin
			// strobes come from next_state so they line up with the state
			cycle_start_strobe <= (next_state == st_first);
			bus_input_phase <= !is_write && (next_state == st_two
				|| next_state == st_stall || next_state == st_third);
			// stall flag mirrors the stall state
			stall_indicator <= (next_state == st_stall);
			// low only in third_state so data has settled and is held
			store_strobe_n <= !(is_write && next_state == st_third);
			// status word owns the bus for first_state
			if (next_state == st_first)
			begin
				data_out <= status_of(cycle_type'(q_data[fifo_w-1 -: 3]));
				data_oe_b <= 1'b0;
			end
			// writes keep data driven from state_two to the end
			else if (is_write && next_state != st_idle && next_state != st_released)
			begin
				data_out <= wdata;
				data_oe_b <= 1'b0;
			end
			// reads and idle leave the bus to the responders
			else
				data_oe_b <= 1'b1;
			// read data taken as third_state closes
			rsp_valid <= !is_write && state == st_third && p1_rise;
			if (!is_write && state == st_third && p1_rise)
				rsp_data <= data_in;
		end
	end

	// acknowledge rises on phase one, float follows on phase two
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// reset floats the address bus
			bus_release_ack <= 1'b0;
			release_delay <= 2'b00;
			addr_oe_b <= 1'b1;
		end
		else
		begin
			// reads acknowledge at third_state, writes one period later
			// read grant uses the live request at the ready point,
			// since hold_seen only lands on that same edge
			if (p1_rise && !is_write && (state == st_two || state == st_stall)
				&& ready && bus_release_request)
				bus_release_ack <= 1'b1;
			// write grant waits until the strobe period is over
			else if (hold_seen && p1_rise && state == st_third && is_write)
				bus_release_ack <= 1'b1;
			// halted: no cycle in flight, grant at once
			else if (state == st_halted && p1_rise && bus_release_request)
				bus_release_ack <= 1'b1;
			// request gone: take the buses back
			else if (state == st_released && p1_rise && !bus_release_request)
				bus_release_ack <= 1'b0;
			// count phase two edges seen under acknowledge
			if (!bus_release_ack)
				release_delay <= 2'b00;
			else if (p2_rise && release_delay != 2'b11)
				release_delay <= release_delay + 2'b01;
			// address floats after the phase two edge following ack
			addr_oe_b <= (bus_release_ack && release_delay != 2'b00)
				|| (state == st_idle && !bus_release_ack && hold_seen);
		end
	end
endmodule : cpu_bus_control
`default_nettype wire

// file: bench/cpu_bus_control_sva.sv
// pin-level checker for the bus sequencer
// assumes it is bound onto cpu_bus_control, single clock domain
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_control_chk (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ready,
	input wire logic bus_release_request,
	input wire logic cycle_start_strobe,
	input wire logic stall_indicator,
	input wire logic store_strobe_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe_b,
	input wire logic addr_oe_b,
	input wire logic bus_release_ack,
	input wire logic irq_taken,
	input wire logic irq_enable_state,
	input wire logic [15:0] program_counter
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// status word owns the data bus in first_state
	property p_status; cycle_start_strobe |-> !data_oe_b && store_strobe_n; endproperty
	a_status: assert property (p_status) else $error("status word not driven");
	// stall only ends on a sampled ready
	property p_stall; $fell(stall_indicator) |-> $past(ready); endproperty
	a_stall: assert property (p_stall) else $error("stall left without ready");
	// write data must not move under the strobe
	property p_wr; !store_strobe_n && $past(!store_strobe_n) |-> $stable(data_out) && !data_oe_b; endproperty
	a_wr: assert property (p_wr) else $error("write data moved");
	// acknowledge only follows a request
	property p_ack; $rose(bus_release_ack) |-> $past(bus_release_request); endproperty
	a_ack: assert property (p_ack) else $error("ack without request");
	// long acknowledge means both buses float
	property p_float; bus_release_ack [*8] |-> addr_oe_b && data_oe_b; endproperty
	a_float: assert property (p_float) else $error("buses not floated");
	// accepted interrupt clears the enable soon
	property p_clr; irq_taken |-> ##[1:8] !irq_enable_state; endproperty
	a_clr: assert property (p_clr) else $error("enable not cleared");
	// disabled means no acceptance
	property p_mask; !irq_enable_state |-> !irq_taken; endproperty
	a_mask: assert property (p_mask) else $error("irq taken while disabled");
	// reset values seen at release
	property p_rst; $rose(rst_b) |-> program_counter == 16'h0000 && !irq_enable_state && !bus_release_ack; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
endmodule : cpu_bus_control_chk
bind cpu_bus_control cpu_bus_control_chk u_chk (.clock(clock), .rst_b(rst_b), .ready(ready),
	.bus_release_request(bus_release_request), .cycle_start_strobe(cycle_start_strobe),
	.stall_indicator(stall_indicator), .store_strobe_n(store_strobe_n), .data_out(data_out),
	.data_oe_b(data_oe_b), .addr_oe_b(addr_oe_b), .bus_release_ack(bus_release_ack),
	.irq_taken(irq_taken), .irq_enable_state(irq_enable_state), .program_counter(program_counter));
`default_nettype wire

// file: bench/cpu_bus_mem_model.sv
// memory and port responder on the far side of the pins
// assumes low address byte selects one of 256 locations
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_mem_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [15:0] addr_out,
	input wire logic [7:0] data_out,
	input wire logic store_strobe_n,
	input wire logic bus_input_phase,
	input wire logic cycle_start_strobe,
	input wire logic [3:0] wait_cycles,
	output logic [7:0] data_in,
	output logic ready
);
	logic [7:0] mem [256]; // shared by memory and ports
	logic [3:0] cnt; // cycles since the cycle start strobe ended
	logic [7:0] last; // last byte handed over
	// slow device: count out the programmed delay
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
			cnt <= 4'h0;
		else if (cycle_start_strobe)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
	// ready only once data stands, held to next cycle start
	assign ready = !cycle_start_strobe && cnt >= wait_cycles;
	// store on the active-low strobe
	always_ff @(posedge clock)
		if (!store_strobe_n)
			mem[addr_out[7:0]] <= data_out;
	// drive only in the input phase, else a changed pattern
	assign data_in = bus_input_phase ? mem[addr_out[7:0]] : ~last;
	always_ff @(posedge clock)
		if (bus_input_phase)
			last <= data_in;
endmodule : cpu_bus_mem_model
`default_nettype wire

// file: bench/cpu_bus_control_tb_top.sv
// self-checking bench for the bus sequencer
// assumes the memory model on the far side and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "cpu_bus_cfg.svh"
module cpu_bus_control_tb_top;
	import cpu_bus_pkg::*;
	logic clock = 0, rst_b = 0, phase_one_clock = 0, phase_two_clock = 0, req_valid = 0;
	logic req_last = 0, enable_irq_instruction = 0, disable_irq_instruction = 0;
	logic bus_release_request = 0, irq_line = 0, req_ready, rsp_valid, addr_oe_b, data_oe_b;
	logic cycle_start_strobe, bus_input_phase, stall_indicator, store_strobe_n, ready;
	logic bus_release_ack, irq_enable_state, irq_taken, saw_stall = 0, saw_irq = 0;
	logic [2:0] req_kind = 3'h0;
	logic [15:0] req_addr = 16'h0000, addr_out, program_counter;
	logic [7:0] req_wdata = 8'h00, rsp_data, data_in, data_out, last_rsp, last_status;
	logic [3:0] wait_cycles = 4'h0; // responder delay
	logic [1:0] ph = 2'h0; // phase slot within four clocks
	int failures = 0, checks = 0, rsp_count = 0, i;
	always #5 clock = ~clock;
	// p1 then p2, never overlapping
	always @(posedge clock)
	begin
		#1;
		ph = ph + 2'h1;
		phase_one_clock = (ph == 2'h0);
		phase_two_clock = (ph == 2'h2);
	end
	// response and stall monitor
	always @(posedge clock)
	begin
		if (rsp_valid)
		begin
			rsp_count++;
			last_rsp = rsp_data;
		end
		if (stall_indicator)
			saw_stall = 1;
		// irq_taken is a comb pulse, caught here at the edge
		if (irq_taken)
			saw_irq = 1;
		// status word as driven in first_state
		if (cycle_start_strobe)
			last_status = data_out;
	end
	cpu_bus_control dut (.clock(clock), .rst_b(rst_b), .phase_one_clock(phase_one_clock),
		.phase_two_clock(phase_two_clock), .req_valid(req_valid), .req_ready(req_ready),
		.req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .req_last(req_last),
		.rsp_data(rsp_data), .rsp_valid(rsp_valid), .enable_irq_instruction(enable_irq_instruction),
		.disable_irq_instruction(disable_irq_instruction), .halt_request(1'b0),
		.addr_out(addr_out), .addr_oe_b(addr_oe_b), .data_in(data_in), .data_out(data_out),
		.data_oe_b(data_oe_b), .cycle_start_strobe(cycle_start_strobe),
		.bus_input_phase(bus_input_phase), .stall_indicator(stall_indicator),
		.store_strobe_n(store_strobe_n), .ready(ready), .bus_release_request(bus_release_request),
		.bus_release_ack(bus_release_ack), .irq_line(irq_line), .irq_enable_state(irq_enable_state),
		.irq_taken(irq_taken), .program_counter(program_counter));
	cpu_bus_mem_model far (.clock(clock), .rst_b(rst_b), .addr_out(addr_out), .data_out(data_out),
		.store_strobe_n(store_strobe_n), .bus_input_phase(bus_input_phase),
		.cycle_start_strobe(cycle_start_strobe), .wait_cycles(wait_cycles), .data_in(data_in),
		.ready(ready));
	task automatic stop_test;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// settle past the edge before looking
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	// request held until the fifo takes it
	task automatic push(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d, input logic l);
		req_kind = k;
		req_addr = a;
		req_wdata = d;
		req_last = l;
		req_valid = 1;
		@(posedge clock);
		while (!req_ready)
			@(posedge clock);
		#1;
	endtask : push
	task automatic read(input logic [2:0] k, input logic [15:0] a, input logic [7:0] exp);
		int n;
		n = rsp_count + 1;
		push(k, a, 8'h00, 1'b0);
		req_valid = 0;
		tick(1);
		for (i = 0; i < 3000 && rsp_count < n; i++)
			tick(1);
		chk(last_rsp, exp);
	endtask : read
	// writes then stalled memory, port and fetch reads
	task automatic t_rw;
		wait_cycles = 4'h9;
		push(cyc_mem_write, 16'h0012, 8'ha5, 1'b0);
		push(cyc_io_out, 16'h0034, 8'h3c, 1'b0);
		read(cyc_mem_read, 16'h0012, 8'ha5);
		read(cyc_io_in, 16'h0034, 8'h3c);
		read(cyc_fetch, 16'h0012, 8'ha5);
		chk(last_status, (8'h01 << `ST_M1) | (8'h01 << `ST_MEMR) | (8'h01 << `ST_WO_N));
		chk(saw_stall, 1'b1);
		$display("t_rw done");
	endtask : t_rw
	// back-to-back reads with no stall
	task automatic t_burst;
		int n;
		wait_cycles = 4'h0;
		n = rsp_count + 8;
		repeat (7)
			push(cyc_mem_read, 16'h0012, 8'h00, 1'b0);
		read(cyc_mem_read, 16'h0012, 8'ha5);
		for (i = 0; i < 3000 && rsp_count < n; i++)
			tick(1);
		chk(rsp_count[15:0], n[15:0]);
		$display("t_burst done");
	endtask : t_burst
	// release request during a read
	task automatic t_release;
		wait_cycles = 4'h2;
		bus_release_request = 1;
		push(cyc_mem_read, 16'h0012, 8'h00, 1'b0);
		req_valid = 0;
		for (i = 0; i < 400 && !bus_release_ack; i++)
			tick(1);
		tick(12);
		chk(addr_oe_b, 1'b1);
		chk(data_oe_b, 1'b1);
		bus_release_request = 0;
		for (i = 0; i < 400 && bus_release_ack; i++)
			tick(1);
		chk(bus_release_ack, 1'b0);
		tick(40);
		$display("t_release done");
	endtask : t_release
	// enable, disable, then an accepted request
	task automatic t_irq;
		enable_irq_instruction = 1;
		tick(1);
		enable_irq_instruction = 0;
		tick(3);
		chk(irq_enable_state, 1'b1);
		disable_irq_instruction = 1;
		tick(1);
		disable_irq_instruction = 0;
		tick(3);
		chk(irq_enable_state, 1'b0);
		enable_irq_instruction = 1;
		tick(1);
		enable_irq_instruction = 0;
		irq_line = 1;
		push(cyc_fetch, 16'h0012, 8'h00, 1'b1);
		push(cyc_fetch, 16'h0012, 8'h00, 1'b1);
		req_valid = 0;
		for (i = 0; i < 400 && saw_irq !== 1'b1; i++)
			tick(1);
		chk(saw_irq, 1'b1);
		irq_line = 0;
		tick(10);
		chk(irq_enable_state, 1'b0);
		$display("t_irq done");
	endtask : t_irq
	// main sequence
	initial
	begin
		repeat (8) @(posedge clock);
		#1;
		chk(program_counter, 16'h0000);
		chk(irq_enable_state, 1'b0);
		chk(bus_release_ack, 1'b0);
		rst_b = 1;
		tick(2);
		t_rw;
		t_burst;
		t_release;
		t_irq;
		stop_test;
	end
	// hang guard, far beyond the expected run
	initial
	begin
		#300000;
		failures++;
		stop_test;
	end
endmodule : cpu_bus_control_tb_top
`default_nettype wire
